// ==== sea_pkg.sv ====
package sea_pkg;

	// Address width of the x8 organisation for the largest variant.
	localparam int          ADDR_BITS_DEF = 11;

	// Two-bit opcodes that follow the start bit.
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_ERASE      = 2'h3;
	localparam logic [1:0]  OP_EXT        = 2'h0;

	// Leading address bits that extend opcode zero.
	localparam logic [1:0]  EXT_WEN       = 2'h3;
	localparam logic [1:0]  WRITE_DISABLE_CMD = 2'h0;
	localparam logic [1:0]  ERASE_ALL_CMD     = 2'h2;
	localparam logic [1:0]  WRITE_ALL_CMD     = 2'h1;

	localparam logic [4:0]  OPC_BITS      = 5'h02;
	localparam logic [4:0]  LEN_X8        = 5'h08;
	localparam logic [4:0]  LEN_X16       = 5'h10;
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	localparam logic [1:0]  LANE_LO       = 2'h1;
	localparam logic [1:0]  LANE_HI       = 2'h2;
	localparam logic [1:0]  LANE_BOTH     = 2'h3;

	// Self-timed program cycle; a longest time, so the count rounds down.
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          WRITE_TIME_NS = 4000000;
	localparam int          WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OP,
		ST_ADDR,
		ST_DATA,
		ST_READ,
		ST_SKIP,
		ST_ARM,
		ST_PROG
	} sea_state_t;

endpackage : sea_pkg

// ==== sea_array.sv ====
module sea_array #(
	parameter int WORD_BITS = 10
) (
	input  wire logic                 clk,
	input  wire logic                 we,
	input  wire logic [1:0]           we_lane,
	input  wire logic [WORD_BITS-1:0] waddr,
	input  wire logic [15:0]          wdata,
	input  wire logic [WORD_BITS-1:0] raddr,
	output logic      [15:0]          rdata
);

	logic [15:0] mem [2**WORD_BITS];

	// Each write lane replaces its byte directly; no prior erase is needed.
	always_ff @(posedge clk) begin
		if (we && we_lane[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		if (we && we_lane[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
		rdata <= mem[raddr];
	end

endmodule : sea_array

// ==== sea_core.sv ====
// Functional notes
// - Array is organised as 8-bit or 16-bit locations, chosen by the org input.
// - Capacity follows the variant, 128 bytes up to 2048 bytes, halving between.
// - Seven instructions: read, write, enable, disable, erase, erase all, write all.
// - Read loads the address counter, then shifts out that location serially.
// - Counter increments after each location; stream continues while selected.
// - Counter wraps from the highest location to zero during sequential read.
// - Program cycle is internally timed and ignores the serial clock once started.
// - Write replaces old contents without a separate erase.
// - One write programs exactly one location of the selected width.
// - During programming, busy/ready shows on the data output while selected.
// - Data output is driven only while selected, otherwise released.
// - Instructions are ignored while supply is below the reset threshold.
// - Crossing the threshold resets to standby, idle, with no cycle running.
// - Falling below the threshold stops all response to instructions.
// - Org high selects 16-bit locations, org low selects 8-bit locations.
// - First one sampled on a rising serial clock edge is the start bit.
// - Opcodes 10 read, 01 write, 11 erase; 00 uses two address bits.
module sea_core
	import sea_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_BITS_DEF,
	parameter int WRITE_CYC = WRITE_CYCLES
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic sel_pin,
	input  wire logic sclk_pin,
	input  wire logic sdi_pin,
	input  wire logic org_pin,
	input  wire logic por_ok,
	output logic      sdo,
	output logic      sdo_oe
);

	localparam int TW = $clog2(WRITE_CYC + 1);
	localparam int WB = ADDR_BITS - 1;
	localparam logic [TW-1:0] T_LAST = TW'(WRITE_CYC - 1);
	localparam logic [WB-1:0] SWEEP_LAST = '1;

	// Pins come from outside the clock domain: two flops before any use.
	logic [4:0] sync_m, sync_s;
	logic       sclk_d, sclk_rise;
	logic       sel_s, sclk_s, sdi_s, org_s, por_s;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_m <= '0;
			sync_s <= '0;
			sclk_d <= 1'b0;
		end else begin
			sync_m <= {por_ok, org_pin, sdi_pin, sclk_pin, sel_pin};
			sync_s <= sync_m;
			sclk_d <= sclk_s;
		end
	end

	assign sel_s     = sync_s[0];
	assign sclk_s    = sync_s[1];
	assign sdi_s     = sync_s[2];
	assign org_s     = sync_s[3];
	assign por_s     = sync_s[4];
	assign sclk_rise = sclk_s && !sclk_d;

	// Valid index bits of an address field in the given organisation.
	function automatic logic [ADDR_BITS-1:0] amask(input logic [ADDR_BITS-1:0] a,
		input logic o);
		amask = o ? {1'b0, a[ADDR_BITS-2:0]} : a;
	endfunction : amask
	// Array word that holds a location.
	function automatic logic [WB-1:0] word_of(input logic [ADDR_BITS-1:0] a, input logic o);
		word_of = o ? a[WB-1:0] : a[ADDR_BITS-1:1];
	endfunction : word_of
	// Two leading address bits that extend opcode zero.
	function automatic logic [1:0] ext_of(input logic [ADDR_BITS-1:0] a, input logic o);
		ext_of = o ? a[ADDR_BITS-2 -: 2] : a[ADDR_BITS-1 -: 2];
	endfunction : ext_of

	sea_state_t           state, next_state;
	logic [4:0]           bits, next_bits;
	logic [1:0]           op, next_op;
	logic [ADDR_BITS-1:0] addr_sh, next_addr_sh;
	logic [15:0]          data_sh, next_data_sh;
	logic [ADDR_BITS-1:0] addr_cnt, next_addr_cnt;
	logic [15:0]          out_sh, next_out_sh;
	logic                 sdo_bit, wen, status_show, fill, pend;
	logic                 next_sdo_bit, next_wen, next_status_show, next_fill, next_pend;
	logic [TW-1:0]        timer, next_timer;
	logic [WB-1:0]        sweep, next_sweep;
	logic                 next_sdo, next_sdo_oe;
	logic [ADDR_BITS-1:0] shifted;
	logic [4:0]           alen, dlen;
	logic [15:0]          rdata, cur, wr_word;
	logic                 mem_we;
	logic [1:0]           mem_lane;
	logic [WB-1:0]        mem_waddr;

	assign shifted = {addr_sh[ADDR_BITS-2:0], sdi_s};
	assign alen    = org_s ? 5'(ADDR_BITS - 1) : 5'(ADDR_BITS);
	assign dlen    = org_s ? LEN_X16 : LEN_X8;
	assign wr_word = org_s ? data_sh : {data_sh[7:0], data_sh[7:0]};
	// Location being read, MSB aligned for shifting.
	assign cur     = org_s ? rdata : {(addr_cnt[0] ? rdata[15:8] : rdata[7:0]), ZERO_BYTE};

	sea_array #(
		.WORD_BITS(WB)
	) u_array (
		.clk    (clk),
		.we     (mem_we),
		.we_lane(mem_lane),
		.waddr  (mem_waddr),
		.wdata  (wr_word),
		.raddr  (word_of(addr_cnt, org_s)),
		.rdata  (rdata)
	);

	always_comb begin
		next_state       = state;
		next_bits        = bits;
		next_op          = op;
		next_addr_sh     = addr_sh;
		next_data_sh     = data_sh;
		next_addr_cnt    = addr_cnt;
		next_out_sh      = out_sh;
		{next_sdo_bit, next_wen, next_status_show, next_fill, next_pend} =
			{sdo_bit, wen, status_show, fill, pend};
		next_timer       = timer;
		next_sweep       = sweep;
		mem_we           = 1'b0;
		mem_lane         = '0;
		mem_waddr        = '0;
		unique case (state)
			ST_IDLE: begin
				if (sel_s && sclk_rise && sdi_s) begin
					next_state       = ST_OP;
					next_bits        = '0;
					next_status_show = 1'b0;
				end
			end
			ST_OP: begin
				if (sclk_rise) begin
					next_op   = {op[0], sdi_s};
					next_bits = bits + 5'h01;
					if (next_bits == OPC_BITS) begin
						next_state = ST_ADDR;
						next_bits  = '0;
					end
				end
			end
			ST_ADDR: begin
				if (sclk_rise) begin
					next_addr_sh = shifted;
					next_bits    = bits + 5'h01;
					if (next_bits == alen) begin
						next_bits  = '0;
						next_state = ST_SKIP;
						next_fill  = 1'b0;
						unique case (op)
							OP_READ: begin
								next_addr_cnt = amask(shifted, org_s);
								next_sdo_bit  = 1'b0;
								next_state    = ST_READ;
							end
							OP_WRITE: begin
								if (wen) begin
									next_state = ST_DATA;
								end
							end
							OP_ERASE: begin
								if (wen) begin
									next_data_sh = ERASED_WORD;
									next_state   = ST_ARM;
								end
							end
							OP_EXT: begin
								unique case (ext_of(shifted, org_s))
									EXT_WEN: next_wen = 1'b1;
									WRITE_DISABLE_CMD: next_wen = 1'b0;
									ERASE_ALL_CMD: begin
										if (wen) begin
											next_data_sh = ERASED_WORD;
											next_fill    = 1'b1;
											next_state   = ST_ARM;
										end
									end
									WRITE_ALL_CMD: begin
										if (wen) begin
											next_fill  = 1'b1;
											next_state = ST_DATA;
										end
									end
								endcase
							end
						endcase
					end
				end
			end
			ST_DATA: begin
				if (sclk_rise) begin
					next_data_sh = {data_sh[14:0], sdi_s};
					next_bits    = bits + 5'h01;
					if (next_bits == dlen) begin
						next_bits  = '0;
						next_state = ST_ARM;
					end
				end
			end
			ST_READ: begin
				if (sclk_rise) begin
					if (bits == '0) begin
						next_sdo_bit = cur[15];
						next_out_sh  = {cur[14:0], 1'b0};
					end else begin
						next_sdo_bit = out_sh[15];
						next_out_sh  = {out_sh[14:0], 1'b0};
					end
					next_bits = bits + 5'h01;
					if (next_bits == dlen) begin
						next_bits     = '0;
						next_addr_cnt = amask(addr_cnt + 1'b1, org_s);
					end
				end
			end
			ST_SKIP: begin
			end
			ST_ARM: begin
				// Programming starts when the master deselects.
				if (!sel_s) begin
					next_state       = ST_PROG;
					next_timer       = '0;
					next_sweep       = '0;
					next_pend        = 1'b1;
					next_status_show = 1'b1;
				end
			end
			ST_PROG: begin
				// The serial clock plays no part here.
				if (pend) begin
					mem_we = 1'b1;
					if (fill) begin
						mem_lane   = LANE_BOTH;
						mem_waddr  = sweep;
						next_sweep = sweep + 1'b1;
						next_pend  = (sweep != SWEEP_LAST);
					end else begin
						mem_lane  = org_s ? LANE_BOTH : (addr_sh[0] ? LANE_HI : LANE_LO);
						mem_waddr = word_of(amask(addr_sh, org_s), org_s);
						next_pend = 1'b0;
					end
				end
				if (timer != T_LAST) begin
					next_timer = timer + 1'b1;
				end else if (!pend) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		// Dropping select abandons any partly received instruction.
		if (!sel_s && (state == ST_OP || state == ST_ADDR || state == ST_DATA
			|| state == ST_READ || state == ST_SKIP)) begin
			next_state = ST_IDLE;
		end
		if (!por_s) begin
			next_state       = ST_IDLE;
			next_wen         = 1'b0;
			next_status_show = 1'b0;
			next_pend        = 1'b0;
			next_fill        = 1'b0;
			next_bits        = '0;
			mem_we           = 1'b0;
		end
		next_sdo    = (next_state == ST_READ) ? next_sdo_bit : (next_state != ST_PROG);
		next_sdo_oe = sel_s && por_s && (next_state == ST_READ || (next_status_show
			&& (next_state == ST_IDLE || next_state == ST_PROG)));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			{bits, op, addr_sh, data_sh, addr_cnt, out_sh, timer, sweep} <= '0;
			{sdo_bit, wen, status_show, fill, pend, sdo, sdo_oe} <= '0;
		end else begin
			state <= next_state;
			{bits, op, addr_sh} <= {next_bits, next_op, next_addr_sh};
			{data_sh, addr_cnt, out_sh} <= {next_data_sh, next_addr_cnt, next_out_sh};
			{timer, sweep} <= {next_timer, next_sweep};
			{sdo_bit, wen, status_show} <= {next_sdo_bit, next_wen, next_status_show};
			{fill, pend, sdo, sdo_oe} <= {next_fill, next_pend, next_sdo, next_sdo_oe};
		end
	end

	a_deselect_hiz: assert property (@(posedge clk) disable iff (sys_rst)
		!sel_s |=> !sdo_oe)
		else $error("Data output driven while deselected.");
	a_busy_shown: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_PROG && $past(state == ST_PROG) && $past(sel_s) && $past(por_s)
		&& status_show) |-> (sdo_oe && !sdo))
		else $error("Busy not shown during programming.");
	a_por_blocks: assert property (@(posedge clk) disable iff (sys_rst)
		!por_s |=> (state == ST_IDLE && !wen && !sdo_oe && !mem_we))
		else $error("Device active below supply threshold.");
	a_prog_wen: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_ARM && !sel_s && por_s) |-> wen ##1 (state == ST_PROG))
		else $error("Program cycle without write enable.");
	a_prog_timed: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_PROG && timer != T_LAST && por_s) |=> (state == ST_PROG))
		else $error("Program cycle ended early.");
	a_single_write: assert property (@(posedge clk) disable iff (sys_rst)
		(mem_we && !fill) |=> !mem_we)
		else $error("Single write touched more than one location.");
	a_start_bit: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_IDLE && sel_s && por_s && sclk_rise && sdi_s) |=> (state == ST_OP))
		else $error("Start bit not taken.");
	a_read_load: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_ADDR && sel_s && por_s && sclk_rise && op == OP_READ
		&& bits + 5'h01 == alen) |=> (state == ST_READ && addr_cnt == $past(amask(shifted, org_s))))
		else $error("Read address not loaded.");
	a_read_inc: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_READ && sel_s && por_s && sclk_rise && bits + 5'h01 == dlen
		&& addr_cnt != amask('1, org_s) && $stable(org_s))
		|=> (addr_cnt == $past(addr_cnt) + 1'b1))
		else $error("Address counter did not advance.");
	a_wrap_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_READ && sel_s && por_s && sclk_rise && bits + 5'h01 == dlen
		&& addr_cnt == amask('1, org_s)) |=> (addr_cnt == '0))
		else $error("Address counter did not wrap to zero.");

endmodule : sea_core

// ==== sea_master.sv ====
module sea_master
	import sea_pkg::*;
(
	input  wire logic clk,
	input  wire logic sdo_line,
	output logic      sel_pin,
	output logic      sclk_pin,
	output logic      sdi_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sel_pin = 1'b0;
		sclk_pin = 1'b0;
		sdi_pin = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Each bit is a 400 ns serial clock; the line is sampled just before the rise.
	task automatic shift(input int n, input logic [47:0] v, output logic [47:0] q);
		q = '0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_pin = v[i];
			sclk_pin = 1'b0;
			tick(4);
			q = {q[46:0], sdo_line};
			sclk_pin = 1'b1;
			tick(4);
		end
		sclk_pin = 1'b0;
	endtask : shift

	task automatic sel_on();
		sclk_pin = 1'b0;
		sel_pin = 1'b1;
		tick(4);
	endtask : sel_on

	task automatic sel_off();
		tick(4);
		sel_pin = 1'b0;
		tick(8);
	endtask : sel_off

	task automatic instr(input logic [1:0] op, input logic [10:0] a, input int ab,
			input logic [15:0] d, input int db);
		logic [47:0] q;
		sel_on();
		shift(3, {45'h0, 1'b1, op}, q);
		shift(ab, {37'h0, a}, q);
		if (db > 0) begin
			shift(db, {32'h0, d}, q);
		end
		sel_off();
	endtask : instr

	// The first sample after the address is the dummy zero.
	task automatic rd(input logic [10:0] a, input int ab, input int nb, output logic [47:0] q);
		sel_on();
		shift(3, {45'h0, 1'b1, OP_READ}, q);
		shift(ab, {37'h0, a}, q);
		shift(nb + 1, 48'h0, q);
		sel_off();
	endtask : rd

	// Reselects and keeps the serial clock running while the status is busy.
	task automatic poll(output logic first, output int n);
		logic [47:0] q;
		sel_on();
		tick(4);
		first = sdo_line;
		n = 0;
		while (sdo_line !== 1'b1 && n < 100) begin
			shift(1, 48'h0, q);
			n++;
		end
		sel_off();
	endtask : poll

endmodule : sea_master

// ==== sea_core_tb_top.sv ====
module sea_core_tb_top;
	import sea_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int AB = 7;
	localparam int WC = 200;

	logic clk;
	logic sys_rst;
	logic org_pin;
	logic por_ok;
	logic sdo;
	logic sdo_oe;
	logic sel_pin;
	logic sclk_pin;
	logic sdi_pin;
	logic q_last = 1'b0;
	logic sdo_line;
	int   n_fail = 0;
	int   total_checks = 0;

	sea_core #(.ADDR_BITS(AB), .WRITE_CYC(WC)) sea_core_inst (
		.clk(clk), .sys_rst(sys_rst), .sel_pin(sel_pin), .sclk_pin(sclk_pin),
		.sdi_pin(sdi_pin), .org_pin(org_pin), .por_ok(por_ok), .sdo(sdo), .sdo_oe(sdo_oe)
	);

	sea_master sea_master_inst (
		.clk(clk), .sdo_line(sdo_line), .sel_pin(sel_pin), .sclk_pin(sclk_pin),
		.sdi_pin(sdi_pin)
	);

	// A released line shows the inverse of its last driven level.
	always @(posedge clk) begin
		if (sdo_oe) begin
			q_last <= sdo;
		end
	end
	assign sdo_line = sdo_oe ? sdo : ~q_last;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_span(input int el);
		total_checks++;
		if (el < WC - 6 || el > WC + 20) begin
			n_fail++;
			$display("ERROR %0t: busy lasted %0d cycles", $time, el);
		end
	endtask : chk_span

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic do_reset();
		sys_rst = 1'b1;
		tick(16);
		sys_rst = 1'b0;
		tick(8);
	endtask : do_reset

	task automatic ext(input logic [1:0] e, input int ab, input logic [15:0] d, input int db);
		sea_master_inst.instr(OP_EXT, 11'(e) << (ab - 2), ab, d, db);
	endtask : ext

	task automatic prog_wait();
		logic first;
		int   n;
		sea_master_inst.poll(first, n);
		chk({47'h0, first}, 48'h0);
		chk_span(8 * n + 13);
		chk({47'h0, sdo_oe}, 48'h0);
	endtask : prog_wait

	task automatic rd_chk(input logic [10:0] a, input int ab, input int nb, input logic [47:0] e);
		logic [47:0] q;
		sea_master_inst.rd(a, ab, nb, q);
		chk(q, e);
		chk({47'h0, sdo_oe}, 48'h0);
	endtask : rd_chk

	task automatic t_write_all();
		ext(EXT_WEN, AB, 16'h0000, 0);
		ext(WRITE_ALL_CMD, AB, 16'h00A5, 8);
		prog_wait();
		rd_chk(11'h000, AB, 16, 48'hA5A5);
	endtask : t_write_all

	task automatic t_write_wrap();
		sea_master_inst.instr(OP_WRITE, 11'h07F, AB, 16'h003C, 8);
		prog_wait();
		sea_master_inst.instr(OP_WRITE, 11'h000, AB, 16'h00C3, 8);
		prog_wait();
		rd_chk(11'h07F, AB, 24, 48'h3CC3A5);
	endtask : t_write_wrap

	task automatic t_erase();
		sea_master_inst.instr(OP_ERASE, 11'h001, AB, 16'h0000, 0);
		prog_wait();
		rd_chk(11'h000, AB, 16, 48'hC3FF);
	endtask : t_erase

	task automatic t_disable();
		ext(WRITE_DISABLE_CMD, AB, 16'h0000, 0);
		sea_master_inst.instr(OP_WRITE, 11'h000, AB, 16'h0000, 8);
		ext(ERASE_ALL_CMD, AB, 16'h0000, 0);
		rd_chk(11'h000, AB, 16, 48'hC3FF);
	endtask : t_disable

	task automatic t_power();
		ext(EXT_WEN, AB, 16'h0000, 0);
		por_ok = 1'b0;
		tick(8);
		sea_master_inst.instr(OP_WRITE, 11'h000, AB, 16'h0000, 8);
		por_ok = 1'b1;
		tick(8);
		sea_master_inst.instr(OP_WRITE, 11'h000, AB, 16'h0000, 8);
		rd_chk(11'h000, AB, 8, 48'hC3);
	endtask : t_power

	task automatic t_wide();
		org_pin = 1'b1;
		do_reset();
		ext(EXT_WEN, AB - 1, 16'h0000, 0);
		ext(ERASE_ALL_CMD, AB - 1, 16'h0000, 0);
		prog_wait();
		sea_master_inst.instr(OP_WRITE, 11'h000, AB - 1, 16'h1234, 16);
		prog_wait();
		rd_chk(11'h03F, AB - 1, 32, 48'hFFFF1234);
	endtask : t_wide

	initial begin
		sys_rst = 1'b1;
		org_pin = 1'b0;
		por_ok = 1'b1;
		do_reset();
		t_write_all();
		t_write_wrap();
		t_erase();
		t_disable();
		t_power();
		t_wide();
		print_verdict();
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		$display("ERROR %0t: run did not finish", $time);
		print_verdict();
	end

endmodule : sea_core_tb_top
